// File: logic/mctopo_pkg.sv
// constants, field layout and types of the multichip topology register bank
package mctopo_pkg;
	// ****************************************
	// build options
	// ****************************************
	localparam logic MULTICHIP = 1'b1;
	localparam logic CORE_REMOVAL_CAPABLE = 1'b1;
	localparam int NUM_CHIPS = 4;
	localparam int CHIP_IDX_W = 2;
	localparam int NUM_RDOFF_REGS = 8;
	localparam int RDOFF_IDX_W = 3;
	localparam int NUM_CORES = 512;
	localparam int CORE_IDX_W = 9;
	localparam int CHIP_ADDR_WIDTH = 36;
	localparam int MASTER_ADDR_WIDTH = 48;
	localparam int MM_HI_W = MASTER_ADDR_WIDTH - 16;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [11:0] DCHIP_OFS = 12'h000;
	localparam logic [11:0] CHIP_BASE_OFS = 12'h040;
	localparam logic [11:0] RDOFF_BASE_OFS = 12'h080;
	localparam logic [11:0] VCFG_OFS = 12'h0c0;
	localparam logic [11:0] BUILD_STATUS_OFS = 12'h0c8;

	// ****************************************
	// field positions
	// ****************************************
	localparam int OWNER_LSB = 4;
	localparam int OWNER_W = 6;
	localparam int DCHIP_PENDING_BIT = 0;
	localparam int CHIP_ONLINE_BIT = 0;
	localparam int CHIP_PENDING_BIT = 1;
	localparam int SPI_BLOCKS_LSB = 3;
	localparam int SPI_MIN_LSB = 9;
	localparam int SPI_FIELD_W = 6;
	localparam logic [5:0] SPI_MAX_VALUE = 6'h3e;
	localparam int CHIP_ADDR_LSB = 16;
	localparam logic [63:0] CHIP_RW_MASK = 64'h000f_ffff_ffff_7ff9;
	localparam int BS_LAST_LSB = 4;
	localparam int BS_LEFT_BIT = 13;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0] OWNER_RST = 6'h00;
	localparam logic [63:0] CHIP_CFG_RST = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RDOFF_RST = 64'h0000_0000_0000_0000;

	typedef logic [63:0] reg64_t;
	typedef logic [CORE_IDX_W-1:0] core_idx_t;
endpackage : mctopo_pkg

// File: logic/removal_if.sv
// carrier between the register bank and the core removal summary
`timescale 1ns/100ps
interface removal_if;
	logic [mctopo_pkg::NUM_CORES-1:0] removed;
	mctopo_pkg::core_idx_t last_idx;
	logic any_left;
	modport bank (output removed, input last_idx, input any_left);
	modport summary (input removed, output last_idx, output any_left);
endinterface : removal_if

// File: logic/core_removal_summary.sv
// finds the last redistributor that survives core removal
`timescale 1ns/100ps
module core_removal_summary (
	removal_if.summary rm
);
	// ****************************************
	// highest surviving core
	// ****************************************
	function automatic logic [mctopo_pkg::CORE_IDX_W:0] last_left(
		input logic [mctopo_pkg::NUM_CORES-1:0] removed);
		logic [mctopo_pkg::CORE_IDX_W:0] res;
		res = '0;
		for (int i = 0; i < mctopo_pkg::NUM_CORES; i++) begin
			if (!removed[i]) begin
				res = {1'b1, i[mctopo_pkg::CORE_IDX_W-1:0]};
			end
		end
		return res;
	endfunction : last_left

	logic [mctopo_pkg::CORE_IDX_W:0] res;

	// RQ16: bit order is page order
	always_comb begin
		res = last_left(rm.removed);
		rm.any_left = res[mctopo_pkg::CORE_IDX_W];
		rm.last_idx = res[mctopo_pkg::CORE_IDX_W-1:0];
	end
endmodule : core_removal_summary

// File: logic/multichip_topology_regs.sv
// multichip chip configuration and core removal register bank on APB
// Functional notes
// RQ1: default chip, chip config and core removal registers answer Secure accesses only.
// RQ2: default chip and chip config registers exist only in multichip builds.
// RQ3: default chip bits 9:4 hold routing table owner, zero to highest chip.
// RQ4: power update pending reads at chip bit 1 and default bit 0.
// RQ5: one 64-bit chip config register per chip, selected by chip number.
// RQ6: chip config writes dropped while any interrupt group enable is set.
// RQ7: stream destination routing driven from chip address bits 51:16.
// RQ8: memory mapped upper write address bits driven from chip address field.
// RQ9: chip address field starts at bit 16, width set by build parameter.
// RQ10: bits 14:9 set minimum interrupts per shared block, values 0 to 62.
// RQ11: bits 8:3 set number of shared interrupt blocks, values 0 to 62.
// RQ12: bit 0 of each chip config register sets chip offline or online.
// RQ13: chip state zero means offline, one means online.
// RQ14: core removal registers exist only when removal capability is built in.
// RQ15: eight 64-bit removal registers; bit m of n removes core 64n+m.
// RQ16: removal bit order follows redistributor page order of the address map.
// RQ17: last redistributor indication moves to last remaining redistributor.
// RQ18: auxiliary distributor page sits just above last remaining redistributor page.
// RQ19: RAM scrub and error insertion limited to lines still in use.
// RQ20: software programs removal registers first, before any processor message.
// RQ21: 64-bit read-back of final virtual config table access attributes.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module multichip_topology_regs (
	// clock, reset, enable
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [2:0] PPROT,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// distributor state
	input wire logic GROUP0_ENABLE,
	input wire logic GROUP1_NONSECURE_ENABLE,
	input wire logic GROUP1_SECURE_ENABLE,
	input wire logic [mctopo_pkg::NUM_CHIPS-1:0] POWER_UPDATE_PENDING,
	input wire logic [63:0] VCFG_ATTR,
	// cross-chip routing
	input wire logic [mctopo_pkg::CHIP_IDX_W-1:0] DEST_CHIP,
	output logic [mctopo_pkg::CHIP_ADDR_WIDTH-1:0] STREAM_DEST,
	output logic [mctopo_pkg::MM_HI_W-1:0] MM_AWADDR_HI,
	output logic [mctopo_pkg::NUM_CHIPS-1:0] CHIP_ONLINE,
	output logic [mctopo_pkg::OWNER_W-1:0] ROUTING_TABLE_OWNER,
	// reduced core set
	output logic [mctopo_pkg::CORE_IDX_W-1:0] LAST_RD_INDEX,
	output logic [mctopo_pkg::CORE_IDX_W:0] AUX_PAGE_INDEX,
	output logic [mctopo_pkg::CORE_IDX_W:0] RAM_LINE_LIMIT,
	output logic CORES_LEFT
);
	// ****************************************
	// decode functions
	// ****************************************
	function automatic logic hit_chip(input logic [11:0] a);
		return mctopo_pkg::MULTICHIP && (a[11:5] == mctopo_pkg::CHIP_BASE_OFS[11:5]);
	endfunction : hit_chip

	function automatic logic hit_rdoff(input logic [11:0] a);
		return mctopo_pkg::CORE_REMOVAL_CAPABLE &&
			(a[11:6] == mctopo_pkg::RDOFF_BASE_OFS[11:6]);
	endfunction : hit_rdoff

	function automatic logic hit_dchip(input logic [11:0] a);
		return mctopo_pkg::MULTICHIP && (a[11:2] == mctopo_pkg::DCHIP_OFS[11:2]);
	endfunction : hit_dchip

	function automatic logic secure_only(input logic [11:0] a);
		return hit_chip(a) || hit_rdoff(a) || hit_dchip(a);
	endfunction : secure_only

	function automatic logic [63:0] merge_half(input logic [63:0] old,
		input logic [31:0] wd, input logic [3:0] strb, input logic hi);
		logic [63:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[(hi ? 32 : 0) + 8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_half

	// ****************************************
	// state
	// ****************************************
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_rdata;
	logic nxt_err;
	logic [5:0] owner_ff;
	logic [mctopo_pkg::NUM_CHIPS-1:0] pending_ff;
	mctopo_pkg::reg64_t chip_cfg_ff [mctopo_pkg::NUM_CHIPS];
	mctopo_pkg::reg64_t rdoff_ff [mctopo_pkg::NUM_RDOFF_REGS];
	logic wr_en;
	logic grp_any;
	logic [mctopo_pkg::CHIP_ADDR_WIDTH-1:0] stream_ff;
	logic [mctopo_pkg::MM_HI_W-1:0] mm_hi_ff;
	logic [mctopo_pkg::NUM_CHIPS-1:0] online_ff;
	mctopo_pkg::core_idx_t last_ff;
	logic [mctopo_pkg::CORE_IDX_W:0] aux_ff;
	logic [mctopo_pkg::CORE_IDX_W:0] ram_ff;
	logic left_ff;

	removal_if rm ();

	core_removal_summary u_summary (
		.rm(rm.summary)
	);

	// ****************************************
	// apb slave: registered answer, one wait-free access phase
	// ****************************************
	assign wr_en = CE && PSEL && PENABLE && pready_ff && PWRITE && !pslverr_ff;
	assign grp_any = GROUP0_ENABLE || GROUP1_NONSECURE_ENABLE || GROUP1_SECURE_ENABLE;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_err = 1'b0;
		if (PADDR[1:0] != 2'h0) begin
			nxt_err = 1'b1;
		// RQ1: secure only
		end else if (PPROT[1] && secure_only(PADDR)) begin
			nxt_err = 1'b1;
		// RQ3: owner field
		end else if (hit_dchip(PADDR)) begin
			nxt_rdata[mctopo_pkg::OWNER_LSB +: mctopo_pkg::OWNER_W] = owner_ff;
			// RQ4: pending flag
			nxt_rdata[mctopo_pkg::DCHIP_PENDING_BIT] = |pending_ff;
		// RQ5: chip select
		end else if (hit_chip(PADDR)) begin
			if (PADDR[2]) begin
				nxt_rdata = chip_cfg_ff[PADDR[4:3]][63:32];
			end else begin
				nxt_rdata = chip_cfg_ff[PADDR[4:3]][31:0];
				nxt_rdata[mctopo_pkg::CHIP_PENDING_BIT] = pending_ff[PADDR[4:3]];
			end
		end else if (hit_rdoff(PADDR)) begin
			nxt_rdata = PADDR[2] ? rdoff_ff[PADDR[5:3]][63:32] : rdoff_ff[PADDR[5:3]][31:0];
		// RQ21: attribute read-back
		end else if (PADDR[11:3] == mctopo_pkg::VCFG_OFS[11:3]) begin
			nxt_rdata = PADDR[2] ? VCFG_ATTR[63:32] : VCFG_ATTR[31:0];
		end else if (PADDR[11:2] == mctopo_pkg::BUILD_STATUS_OFS[11:2]) begin
			nxt_rdata[0] = mctopo_pkg::MULTICHIP;
			nxt_rdata[1] = mctopo_pkg::CORE_REMOVAL_CAPABLE;
			nxt_rdata[mctopo_pkg::BS_LAST_LSB +: mctopo_pkg::CORE_IDX_W] = last_ff;
			nxt_rdata[mctopo_pkg::BS_LEFT_BIT] = left_ff;
		end else begin
			// RQ2: absent in single chip builds
			nxt_err = 1'b1;
		end
	end

	// answer is formed in the setup cycle so PRDATA can come straight from a flop
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (CE) begin
			pready_ff <= PSEL && !PENABLE;
			if (PSEL && !PENABLE) begin
				pslverr_ff <= nxt_err;
				prdata_ff <= (PWRITE || nxt_err) ? 32'h0000_0000 : nxt_rdata;
			end
		end
	end

	assign PREADY = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign PRDATA = prdata_ff;

	// ****************************************
	// default chip register
	// ****************************************
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			owner_ff <= mctopo_pkg::OWNER_RST;
			pending_ff <= '0;
		end else if (CE) begin
			pending_ff <= POWER_UPDATE_PENDING;
			// RQ3: out of range owner ignored
			if (wr_en && hit_dchip(PADDR) && PSTRB[0] && PSTRB[1] &&
				(PWDATA[mctopo_pkg::OWNER_LSB +: mctopo_pkg::OWNER_W] <
				6'(mctopo_pkg::NUM_CHIPS))) begin
				owner_ff <= PWDATA[mctopo_pkg::OWNER_LSB +: mctopo_pkg::OWNER_W];
			end
		end
	end

	// ****************************************
	// per-chip configuration registers
	// ****************************************
	for (genvar g = 0; g < mctopo_pkg::NUM_CHIPS; g++) begin : g_chip
		mctopo_pkg::reg64_t nxt_cfg;
		always_comb begin
			nxt_cfg = merge_half(chip_cfg_ff[g], PWDATA, PSTRB, PADDR[2]) &
				mctopo_pkg::CHIP_RW_MASK;
			// RQ10: illegal minimum keeps old value
			if (nxt_cfg[mctopo_pkg::SPI_MIN_LSB +: mctopo_pkg::SPI_FIELD_W] >
				mctopo_pkg::SPI_MAX_VALUE) begin
				nxt_cfg[mctopo_pkg::SPI_MIN_LSB +: mctopo_pkg::SPI_FIELD_W] =
					chip_cfg_ff[g][mctopo_pkg::SPI_MIN_LSB +: mctopo_pkg::SPI_FIELD_W];
			end
			// RQ11: illegal block count kept out
			if (nxt_cfg[mctopo_pkg::SPI_BLOCKS_LSB +: mctopo_pkg::SPI_FIELD_W] >
				mctopo_pkg::SPI_MAX_VALUE) begin
				nxt_cfg[mctopo_pkg::SPI_BLOCKS_LSB +: mctopo_pkg::SPI_FIELD_W] =
					chip_cfg_ff[g][mctopo_pkg::SPI_BLOCKS_LSB +: mctopo_pkg::SPI_FIELD_W];
			end
		end
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				chip_cfg_ff[g] <= mctopo_pkg::CHIP_CFG_RST;
			// RQ6: writes dropped while enabled
			end else if (CE && wr_en && hit_chip(PADDR) && !grp_any &&
				(PADDR[4:3] == (mctopo_pkg::CHIP_IDX_W)'(g))) begin
				chip_cfg_ff[g] <= nxt_cfg;
			end
		end
	end

	// ****************************************
	// core removal registers
	// ****************************************
	for (genvar r = 0; r < mctopo_pkg::NUM_RDOFF_REGS; r++) begin : g_rdoff
		always_ff @(posedge CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				rdoff_ff[r] <= mctopo_pkg::RDOFF_RST;
			// RQ15: bit m of n is core 64n+m
			end else if (CE && wr_en && hit_rdoff(PADDR) &&
				(PADDR[5:3] == (mctopo_pkg::RDOFF_IDX_W)'(r))) begin
				rdoff_ff[r] <= merge_half(rdoff_ff[r], PWDATA, PSTRB, PADDR[2]);
			end
		end
		// RQ14: zero mask when not built
		assign rm.removed[64*r +: 64] = mctopo_pkg::CORE_REMOVAL_CAPABLE ? rdoff_ff[r] : '0;
	end

	// ****************************************
	// outputs toward the rest of the distributor
	// ****************************************
	// the route follows DEST_CHIP one cycle late; transport must sample accordingly
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stream_ff <= '0;
			mm_hi_ff <= '0;
			online_ff <= '0;
		end else if (CE) begin
			// RQ7: stream destination
			// RQ9: field from bit 16
			stream_ff <= chip_cfg_ff[DEST_CHIP][mctopo_pkg::CHIP_ADDR_LSB +:
				mctopo_pkg::CHIP_ADDR_WIDTH];
			// RQ8: upper write address
			mm_hi_ff <= chip_cfg_ff[DEST_CHIP][mctopo_pkg::CHIP_ADDR_LSB +:
				mctopo_pkg::MM_HI_W];
			for (int c = 0; c < mctopo_pkg::NUM_CHIPS; c++) begin
				// RQ12: chip state bit
				// RQ13: one means online
				online_ff[c] <= chip_cfg_ff[c][mctopo_pkg::CHIP_ONLINE_BIT];
			end
		end
	end

	// software is trusted to program removal first; later changes still track but are unsafe
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			last_ff <= '0;
			aux_ff <= '0;
			ram_ff <= '0;
			left_ff <= 1'b0;
		end else if (CE) begin
			// RQ17: last redistributor moves
			last_ff <= rm.last_idx;
			left_ff <= rm.any_left;
			// RQ18: aux page above last
			aux_ff <= rm.any_left ? ({1'b0, rm.last_idx} + 10'h001) : 10'h000;
			// RQ19: scrub limited to used lines
			ram_ff <= rm.any_left ? ({1'b0, rm.last_idx} + 10'h001) : 10'h000;
		end
	end

	assign STREAM_DEST = stream_ff;
	assign MM_AWADDR_HI = mm_hi_ff;
	assign CHIP_ONLINE = online_ff;
	assign ROUTING_TABLE_OWNER = owner_ff;
	assign LAST_RD_INDEX = last_ff;
	assign AUX_PAGE_INDEX = aux_ff;
	assign RAM_LINE_LIMIT = ram_ff;
	assign CORES_LEFT = left_ff;

	// ****************************************
	// assertions
	// ****************************************
	property p_secure;
		@(posedge CLK) disable iff (!ARST_N)
		(CE && PSEL && !PENABLE && PPROT[1] && secure_only(PADDR)) |=>
			(PREADY && PSLVERR && PRDATA == 32'h0000_0000);
	endproperty
	a_secure: assert property (p_secure) else $error("non-secure access not refused"); // RQ1

	property p_absent;
		@(posedge CLK) disable iff (!ARST_N)
		(CE && PSEL && !PENABLE && !PPROT[1] && PADDR == mctopo_pkg::DCHIP_OFS)
			|=> PSLVERR == !mctopo_pkg::MULTICHIP;
	endproperty
	a_absent: assert property (p_absent) else $error("default chip reg presence wrong"); // RQ2

	property p_owner;
		@(posedge CLK) disable iff (!ARST_N)
		ROUTING_TABLE_OWNER < 6'(mctopo_pkg::NUM_CHIPS);
	endproperty
	a_owner: assert property (p_owner) else $error("owner beyond highest chip"); // RQ3

	property p_pending;
		@(posedge CLK) disable iff (!ARST_N)
		(CE && PSEL && !PENABLE && !PWRITE && !PPROT[1] && PADDR == mctopo_pkg::DCHIP_OFS)
			|=> PRDATA[mctopo_pkg::DCHIP_PENDING_BIT] == $past(|pending_ff);
	endproperty
	a_pending: assert property (p_pending) else $error("pending flag wrong"); // RQ4

	property p_guard;
		@(posedge CLK) disable iff (!ARST_N)
		(wr_en && hit_chip(PADDR) && grp_any) |=> $stable(chip_cfg_ff[0]) &&
			$stable(chip_cfg_ff[1]) && $stable(chip_cfg_ff[2]) && $stable(chip_cfg_ff[3]);
	endproperty
	a_guard: assert property (p_guard) else $error("chip config written while enabled"); // RQ6

	property p_stream;
		@(posedge CLK) disable iff (!ARST_N)
		CE ##1 CE |-> STREAM_DEST ==
			$past(chip_cfg_ff[DEST_CHIP][51:16]);
	endproperty
	a_stream: assert property (p_stream) else $error("stream destination mismatch"); // RQ7

	property p_mm;
		@(posedge CLK) disable iff (!ARST_N)
		CE ##1 CE |-> MM_AWADDR_HI == STREAM_DEST[mctopo_pkg::MM_HI_W-1:0];
	endproperty
	a_mm: assert property (p_mm) else $error("write address high bits mismatch"); // RQ8

	property p_spi;
		@(posedge CLK) disable iff (!ARST_N)
		chip_cfg_ff[DEST_CHIP][14:9] != 6'h3f && chip_cfg_ff[DEST_CHIP][8:3] != 6'h3f;
	endproperty
	a_spi: assert property (p_spi) else $error("shared block field out of range"); // RQ10

	property p_online;
		@(posedge CLK) disable iff (!ARST_N)
		CE ##1 CE |-> CHIP_ONLINE[0] == $past(chip_cfg_ff[0][0]);
	endproperty
	a_online: assert property (p_online) else $error("chip online mismatch"); // RQ13

	property p_aux;
		@(posedge CLK) disable iff (!ARST_N)
		CORES_LEFT |-> (AUX_PAGE_INDEX == {1'b0, LAST_RD_INDEX} + 10'h001) &&
			(RAM_LINE_LIMIT == AUX_PAGE_INDEX);
	endproperty
	a_aux: assert property (p_aux) else $error("aux page not above last"); // RQ18

	c_chip_write: cover property (@(posedge CLK) wr_en && hit_chip(PADDR) && !grp_any);
	c_guarded: cover property (@(posedge CLK) wr_en && hit_chip(PADDR) && grp_any);
	c_removal: cover property (@(posedge CLK) wr_en && hit_rdoff(PADDR));
	c_nonsec: cover property (@(posedge CLK) PREADY && PSLVERR);
endmodule : multichip_topology_regs

// File: testbench/distributor_state_model.sv
// model of the distributor state that surrounds the register bank
`timescale 1ns/100ps
module distributor_state_model (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// requests from the bench
	input wire logic [2:0] GRP_REQ,
	input wire logic [3:0] PENDING_REQ,
	input wire logic [1:0] DEST_REQ,
	// state seen by the bank
	output logic GROUP0_ENABLE,
	output logic GROUP1_NONSECURE_ENABLE,
	output logic GROUP1_SECURE_ENABLE,
	output logic [mctopo_pkg::NUM_CHIPS-1:0] POWER_UPDATE_PENDING,
	output logic [63:0] VCFG_ATTR,
	output logic [mctopo_pkg::CHIP_IDX_W-1:0] DEST_CHIP
);
	// state moves only just after a rising edge, like the real control logic
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{GROUP1_SECURE_ENABLE, GROUP1_NONSECURE_ENABLE, GROUP0_ENABLE} <= 3'h0;
			POWER_UPDATE_PENDING <= '0;
			DEST_CHIP <= '0;
		end else begin
			{GROUP1_SECURE_ENABLE, GROUP1_NONSECURE_ENABLE, GROUP0_ENABLE} <= GRP_REQ;
			POWER_UPDATE_PENDING <= PENDING_REQ;
			DEST_CHIP <= DEST_REQ;
		end
	end
	// every byte differs so a swapped or shifted word shows up
	assign VCFG_ATTR = 64'h8765_4321_0fed_cba9;
endmodule : distributor_state_model

// File: testbench/multichip_topology_regs_test.sv
// self-checking bench for the multichip topology register bank
`timescale 1ns/100ps
module multichip_topology_regs_test;
	// ****************************************
	// signals
	// ****************************************
	localparam logic [11:0] DC = mctopo_pkg::DCHIP_OFS;
	localparam logic [11:0] C2 = mctopo_pkg::CHIP_BASE_OFS + 12'h010;
	localparam logic [11:0] R0 = mctopo_pkg::RDOFF_BASE_OFS;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] pprot = 3'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] grp_req = 3'h0;
	logic [3:0] pending_req = 4'h0;
	logic [1:0] dest_req = 2'h0;
	logic g0, g1ns, g1s;
	logic [mctopo_pkg::NUM_CHIPS-1:0] pending;
	logic [63:0] vcfg;
	logic [mctopo_pkg::CHIP_IDX_W-1:0] dest;
	logic [mctopo_pkg::CHIP_ADDR_WIDTH-1:0] stream_dest;
	logic [mctopo_pkg::MM_HI_W-1:0] mm_hi;
	logic [mctopo_pkg::NUM_CHIPS-1:0] online;
	logic [mctopo_pkg::OWNER_W-1:0] owner;
	logic [mctopo_pkg::CORE_IDX_W-1:0] last_idx;
	logic [mctopo_pkg::CORE_IDX_W:0] aux_idx;
	logic [mctopo_pkg::CORE_IDX_W:0] ram_lim;
	logic cores_left;
	logic [31:0] rd;
	logic err;
	int mismatches = 0;
	int checks = 0;

	always #20 clk = ~clk;

	distributor_state_model model (.CLK(clk), .ARST_N(arst_n), .GRP_REQ(grp_req),
		.PENDING_REQ(pending_req), .DEST_REQ(dest_req), .GROUP0_ENABLE(g0),
		.GROUP1_NONSECURE_ENABLE(g1ns), .GROUP1_SECURE_ENABLE(g1s),
		.POWER_UPDATE_PENDING(pending), .VCFG_ATTR(vcfg), .DEST_CHIP(dest));

	multichip_topology_regs uut (.CLK(clk), .ARST_N(arst_n), .CE(ce), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PPROT(pprot), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.GROUP0_ENABLE(g0), .GROUP1_NONSECURE_ENABLE(g1ns), .GROUP1_SECURE_ENABLE(g1s),
		.POWER_UPDATE_PENDING(pending), .VCFG_ATTR(vcfg), .DEST_CHIP(dest),
		.STREAM_DEST(stream_dest), .MM_AWADDR_HI(mm_hi), .CHIP_ONLINE(online),
		.ROUTING_TABLE_OWNER(owner), .LAST_RD_INDEX(last_idx), .AUX_PAGE_INDEX(aux_idx),
		.RAM_LINE_LIMIT(ram_lim), .CORES_LEFT(cores_left));

	// ****************************************
	// tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// setup cycle, then access phase held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
			input logic [2:0] prot);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		pprot <= prot;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
		apb(1'b1, addr, wd, 3'h0);
		check("write error", err, 1'b0);
	endtask : wr

	task automatic rd_exp(input string name, input logic [11:0] addr, input logic [31:0] exp,
			input logic [2:0] prot);
		apb(1'b0, addr, 32'h0000_0000, prot);
		check("read error", err, 1'b0);
		check(name, rd, exp);
	endtask : rd_exp

	task automatic refused(input string name, input logic w, input logic [11:0] addr,
			input logic [2:0] prot);
		apb(w, addr, 32'hffff_ffff, prot);
		check(name, {err, rd}, {1'b1, 32'h0000_0000});
	endtask : refused

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		// core set is reduced first, before any other register is touched
		wr(R0 + 12'h03c, 32'h8000_0000);
		settle();
		check("last", last_idx, 9'd510);
		check("aux", aux_idx, 10'd511);
		check("ram", ram_lim, 10'd511);
		for (int i = 0; i < 16; i++) begin
			wr(R0 + 12'(4 * i), 32'hffff_ffff);
		end
		settle();
		check("none left", {cores_left, last_idx, aux_idx}, 20'h0);
		rd_exp("rdoff7 hi", R0 + 12'h03c, 32'hffff_ffff, 3'h0);
		rd_exp("status", mctopo_pkg::BUILD_STATUS_OFS, 32'h0000_0003, 3'h0);
		wr(R0, 32'hffff_ffdf);
		settle();
		check("core 5", {last_idx, aux_idx}, {9'd5, 10'd6});
		// register 3, high word, bit 2 is core 226
		wr(R0 + 12'h01c, 32'hffff_fffb);
		settle();
		check("core 226", {cores_left, last_idx, ram_lim}, {1'b1, 9'd226, 10'd227});
		rd_exp("status", mctopo_pkg::BUILD_STATUS_OFS, 32'h0000_2e23, 3'h0);
		refused("ns rdoff", 1'b1, R0, 3'h2);
		rd_exp("rdoff0 lo", R0, 32'hffff_ffdf, 3'h0);
		rd_exp("dchip rst", DC, 32'h0000_0000, 3'h0);
		wr(DC, 32'h0000_0030);
		rd_exp("owner 3", DC, 32'h0000_0030, 3'h0);
		check("owner out", owner, 6'h03);
		wr(DC, 32'h0000_0050);
		rd_exp("owner 5", DC, 32'h0000_0030, 3'h0);
		wr(DC, 32'hffff_fc0f);
		rd_exp("owner 0", DC, 32'h0000_0000, 3'h0);
		// owner needs both low byte lanes; a lone lane must not land
		pstrb <= 4'h1;
		wr(DC, 32'h0000_0020);
		pstrb <= 4'hf;
		rd_exp("owner strb", DC, 32'h0000_0000, 3'h0);
		refused("ns dchip", 1'b0, DC, 3'h2);
		refused("ns chip", 1'b1, C2, 3'h2);
		refused("misaligned", 1'b0, 12'h002, 3'h0);
		refused("unmapped", 1'b0, 12'h100, 3'h0);
		pending_req <= 4'b0100;
		dest_req <= 2'h2;
		wr(C2, 32'habcd_7bf1);
		wr(C2 + 12'h004, 32'hfff1_2345);
		settle();
		rd_exp("chip2 lo", C2, 32'habcd_7bf3, 3'h0);
		rd_exp("chip2 hi", C2 + 12'h004, 32'h0001_2345, 3'h0);
		rd_exp("chip1 lo", C2 - 12'h008, 32'h0000_0000, 3'h0);
		rd_exp("dchip pend", DC, 32'h0000_0001, 3'h0);
		check("stream", stream_dest, 36'h1_2345_abcd);
		check("mm addr", mm_hi, 32'h2345_abcd);
		check("online", online, 4'b0100);
		// spi field value 63 is kept out, the other fields still land
		wr(C2, 32'habcd_7bf9);
		rd_exp("blocks 63", C2, 32'habcd_7bf3, 3'h0);
		wr(C2, 32'h1234_7e01);
		rd_exp("min 63", C2, 32'h1234_7a03, 3'h0);
		for (int i = 0; i < 3; i++) begin
			grp_req <= 3'(1 << i);
			settle();
			wr(C2, 32'h0000_0000);
			rd_exp("grp block", C2, 32'h1234_7a03, 3'h0);
		end
		grp_req <= 3'h0;
		settle();
		wr(C2, 32'h0000_0000);
		settle();
		rd_exp("chip2 off", C2, 32'h0000_0002, 3'h0);
		check("offline", online, 4'b0000);
		// enable low freezes the route even though the destination moves
		ce <= 1'b0;
		dest_req <= 2'h0;
		settle();
		check("ce hold", stream_dest, 36'h1_2345_0000);
		ce <= 1'b1;
		settle();
		check("dest 0", {stream_dest, mm_hi}, 68'h0);
		rd_exp("vcfg lo", mctopo_pkg::VCFG_OFS, 32'h0fed_cba9, 3'h2);
		rd_exp("vcfg hi", mctopo_pkg::VCFG_OFS + 12'h004, 32'h8765_4321, 3'h2);
		print_verdict();
	end
endmodule : multichip_topology_regs_test
